// >>> shared/arith_pkg.sv
// Shared types and constants of the arithmetic and rotate datapath.
// Assumes one clock; all cycle figures count cpu_clock periods.
package arith_pkg;

    // Operation codes presented on the command port
    typedef enum logic [4:0] {
        OP_WORD_ADD_IMM     = 5'h00,
        OP_WORD_SUB_IMM     = 5'h01,
        OP_WORD_COMPARE_IMM = 5'h02,
        OP_UNSIGNED_MUL     = 5'h03,
        OP_UNSIGNED_DIV     = 5'h04,
        OP_BYTE_INC         = 5'h05,
        OP_BYTE_DEC         = 5'h06,
        OP_PAIR_INC         = 5'h07,
        OP_PAIR_DEC         = 5'h08,
        OP_ROT_RIGHT        = 5'h09,
        OP_ROT_LEFT         = 5'h0a,
        OP_ROT_RIGHT_CARRY  = 5'h0b,
        OP_ROT_LEFT_CARRY   = 5'h0c,
        OP_DIGIT_ROT_RIGHT  = 5'h0d,
        OP_DIGIT_ROT_LEFT   = 5'h0e,
        OP_DEC_ADJUST_ADD   = 5'h0f,
        OP_DEC_ADJUST_SUB   = 5'h10,
        OP_BIT_TO_CARRY     = 5'h11,
        OP_CARRY_TO_BIT     = 5'h12
    } op_type;

    // Cycle counts, first figure then the slow-memory figure
    localparam logic [4:0] CYC_WORD      = 5'h06;
    localparam logic [4:0] CYC_MUL       = 5'h10;
    localparam logic [4:0] CYC_DIV       = 5'h19;
    localparam logic [4:0] CYC_BYTE_REG  = 5'h02;
    localparam logic [4:0] CYC_BYTE_MEM  = 5'h04;
    localparam logic [4:0] CYC_BYTE_SLOW = 5'h06;
    localparam logic [4:0] CYC_PAIR      = 5'h04;
    localparam logic [4:0] CYC_ROT       = 5'h02;
    localparam logic [4:0] CYC_DIGIT     = 5'h0a;
    localparam logic [4:0] CYC_DIGIT_SLOW = 5'h0c;
    localparam logic [4:0] CYC_ADJUST    = 5'h04;
    localparam logic [4:0] CYC_BIT_REG   = 5'h04;
    localparam logic [4:0] CYC_BIT_MEM   = 5'h06;
    localparam logic [4:0] CYC_BIT_RD_SLOW = 5'h07;
    localparam logic [4:0] CYC_BIT_WR_SLOW = 5'h08;

    // Divider settings of the processor clock control, and the divide-by-zero quotient
    localparam int          CLK_SEL_W   = 3;
    localparam logic [2:0]  CLK_SEL_MAX = 3'h4;
    localparam logic [15:0] DIV_ZERO_Q  = 16'hffff;

    // Decimal adjust constants
    localparam logic [7:0] BCD_LOW_FIX  = 8'h06;
    localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
    localparam logic [3:0] BCD_NIB_MAX  = 4'h9;
    localparam logic [7:0] BCD_BYTE_MAX = 8'h99;

    typedef struct packed {
        logic z;
        logic ac;
        logic cy;
    } flags_type;

    // One operation with all operands it may need
    typedef struct packed {
        op_type     op;
        logic [15:0] acc_pair;
        logic [7:0]  x_reg;
        logic [7:0]  c_reg;
        logic [15:0] imm;
        logic [15:0] operand;
        logic [7:0]  mem;
        logic [2:0]  bit_pos;
        logic        use_mem;
        logic        in_hsram;
        flags_type   flags;
    } cmd_type;

    // Everything an operation may write back
    typedef struct packed {
        logic [15:0] acc_pair;
        logic [7:0]  c_reg;
        logic [15:0] operand;
        logic [7:0]  mem;
        flags_type   flags;
    } res_type;

endpackage

// >>> core/cpu_clock_div.sv
// Divider that makes the one-cycle cpu_clock enable from mclk.
// Assumes the select input is steady while an operation runs.
`timescale 1ns/100ps
module cpu_clock_div #(
    parameter int SEL_W = 3,
    parameter int MAX_SEL = 4
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [SEL_W-1:0] sel,
    output logic                  tick
);
    localparam int CNT_W = MAX_SEL + 1;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             tick_nxt;
    logic [CNT_W-1:0] limit;

    // The select input must be able to name the largest setting
    if (MAX_SEL >= (1 << SEL_W) || MAX_SEL < 0) begin : g_bad_sel
        $error("cpu_clock_div: MAX_SEL out of range");
    end

    // Ratio 2**sel; settings above the top clamp to it
    always_comb begin
        if (sel > SEL_W'(MAX_SEL)) begin
            limit = CNT_W'((1 << MAX_SEL) - 1);
        end else begin
            limit = CNT_W'((1 << sel) - 1);
        end
        if (cnt_r >= limit) begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt  = cnt_r + CNT_W'(1);
            tick_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick  <= tick_nxt;
        end
    end
endmodule

// >>> core/arith_datapath.sv
// Arithmetic, rotate, decimal adjust and carry-bit datapath.
// Assumes a sequencer presents one command with start and waits for done.
// Notes on behaviour
// - word add: pair plus immediate, flags, 6
// - word subtract/compare: borrow in carry, 6
// - multiply A by X into pair, 16
// - divide pair by C, remainder C, 25
// - byte increment, Z and AC, carry kept
// - byte decrement, same costs as increment
// - pair increment/decrement, no flags, 4
// - left rotate: bit 7 to bit 0, carry
// - rotate through carry either way, 2 clocks
// - right digit rotate through memory, 10/12
// - left digit rotate through memory, 10/12
// - decimal adjust after add, flags, 4
// - decimal adjust after subtract, flags, 4
// - each count is one cpu_clock period
// - first figure for fast RAM or none
// - longer figure for other memory
`timescale 1ns/100ps
module arith_datapath (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire logic [2:0]                    clock_sel,
    input  wire logic                          start,
    input  wire arith_pkg::cmd_type            cmd,
    output logic                               busy,
    output logic                               done,
    output arith_pkg::res_type                 res
);
    import arith_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } state_type;

    state_type   state_r;
    state_type   state_nxt;
    logic [4:0]  left_r;
    logic [4:0]  left_nxt;
    res_type     res_nxt;
    res_type     hold_r;
    res_type     hold_nxt;
    logic        busy_nxt;
    logic        done_nxt;
    logic        tick;
    res_type     calc;
    logic [4:0]  cyc;
    logic [16:0] wsum;
    logic [4:0]  nsum;
    logic [7:0]  a;
    logic [7:0]  src;
    logic [7:0]  bres;
    logic [7:0]  adj;
    logic        adj_ac;
    logic        adj_cy;

    // Enable once per cpu_clock period
    cpu_clock_div #(
        .SEL_W   (CLK_SEL_W),
        .MAX_SEL (int'(CLK_SEL_MAX))
    ) u_div (
        .mclk (mclk),
        .rst  (rst),
        .sel  (clock_sel),
        .tick (tick)
    );

    // A zero cost would wrap the down-counter and run the sequencer for 32 periods
    if (CYC_WORD == 5'h00 || CYC_MUL == 5'h00 || CYC_DIV == 5'h00
            || CYC_BYTE_REG == 5'h00 || CYC_BYTE_MEM == 5'h00
            || CYC_PAIR == 5'h00 || CYC_ROT == 5'h00
            || CYC_DIGIT == 5'h00 || CYC_ADJUST == 5'h00
            || CYC_BIT_REG == 5'h00 || CYC_BIT_MEM == 5'h00) begin : g_zero
        $error("arith_datapath: zero cycle cost");
    end

    // Slow memory never costs less than fast memory
    if (CYC_BYTE_SLOW < CYC_BYTE_MEM || CYC_DIGIT_SLOW < CYC_DIGIT
            || CYC_BIT_RD_SLOW < CYC_BIT_MEM
            || CYC_BIT_WR_SLOW < CYC_BIT_MEM) begin : g_slow
        $error("arith_datapath: slow cost below fast cost");
    end

    // The accumulator is the low byte of the pair
    assign a = cmd.acc_pair[7:0];

    // Decimal correction of the accumulator byte
    always_comb begin
        adj    = 8'h00;
        adj_ac = 1'b0;
        adj_cy = cmd.flags.cy;
        if (a[3:0] > BCD_NIB_MAX || cmd.flags.ac) begin
            adj = adj | BCD_LOW_FIX;
        end
        // The upper fix forces carry; otherwise carry passes
        if (a > BCD_BYTE_MAX || cmd.flags.cy) begin
            adj    = adj | BCD_HIGH_FIX;
            adj_cy = 1'b1;
        end
        // Auxiliary carry: carry or borrow out of bit 3
        if (cmd.op == OP_DEC_ADJUST_SUB) begin
            adj_ac = a[3:0] < adj[3:0];
        end else begin
            adj_ac = ({1'b0, a[3:0]} + {1'b0, adj[3:0]}) > 5'h0f;
        end
    end

    // Byte operand of increment, decrement and bit moves
    assign src = cmd.use_mem ? cmd.mem : cmd.operand[7:0];

    // Result and cost of the presented command
    always_comb begin
        calc     = '0;
        calc.acc_pair = cmd.acc_pair;
        calc.c_reg    = cmd.c_reg;
        calc.operand  = cmd.operand;
        calc.mem      = cmd.mem;
        calc.flags    = cmd.flags;
        cyc      = CYC_ROT;
        wsum     = '0;
        nsum     = '0;
        bres     = '0;
        case (cmd.op)
            OP_WORD_ADD_IMM: begin
                wsum = {1'b0, cmd.acc_pair} + {1'b0, cmd.imm};
                nsum = {1'b0, cmd.acc_pair[3:0]}
                     + {1'b0, cmd.imm[3:0]};
                calc.acc_pair = wsum[15:0];
                calc.flags.cy = wsum[16];
                calc.flags.z  = (wsum[15:0] == 16'h0000);
                calc.flags.ac = nsum[4];
                cyc = CYC_WORD;
            end
            OP_WORD_SUB_IMM,
            OP_WORD_COMPARE_IMM: begin
                wsum = {1'b0, cmd.acc_pair} - {1'b0, cmd.imm};
                nsum = {1'b0, cmd.acc_pair[3:0]}
                     - {1'b0, cmd.imm[3:0]};
                // Compare keeps the pair and sets only flags
                if (cmd.op == OP_WORD_SUB_IMM) begin
                    calc.acc_pair = wsum[15:0];
                end
                calc.flags.cy = wsum[16];
                calc.flags.z  = (wsum[15:0] == 16'h0000);
                calc.flags.ac = nsum[4];
                cyc = CYC_WORD;
            end
            OP_UNSIGNED_MUL: begin
                // Flags pass through untouched
                calc.acc_pair = 16'(a) * 16'(cmd.x_reg);
                cyc = CYC_MUL;
            end
            OP_UNSIGNED_DIV: begin
                // A zero divisor gives all-ones and keeps C
                if (cmd.c_reg == 8'h00) begin
                    calc.acc_pair = DIV_ZERO_Q;
                end else begin
                    calc.acc_pair = cmd.acc_pair
                                  / {8'h00, cmd.c_reg};
                    calc.c_reg = 8'(cmd.acc_pair
                               % {8'h00, cmd.c_reg});
                end
                cyc = CYC_DIV;
            end
            OP_BYTE_INC,
            OP_BYTE_DEC: begin
                if (cmd.op == OP_BYTE_INC) begin
                    bres = src + 8'h01;
                    calc.flags.ac = (src[3:0] == 4'hf);
                end else begin
                    bres = src - 8'h01;
                    calc.flags.ac = (src[3:0] == 4'h0);
                end
                calc.flags.z = (bres == 8'h00);
                if (cmd.use_mem) begin
                    calc.mem = bres;
                    if (cmd.in_hsram) begin
                        cyc = CYC_BYTE_MEM;
                    end else begin
                        cyc = CYC_BYTE_SLOW;
                    end
                end else begin
                    calc.operand[7:0] = bres;
                    cyc = CYC_BYTE_REG;
                end
            end
            OP_PAIR_INC: begin
                // Pair steps leave every flag alone
                calc.operand = cmd.operand + 16'h0001;
                cyc = CYC_PAIR;
            end
            OP_PAIR_DEC: begin
                calc.operand = cmd.operand - 16'h0001;
                cyc = CYC_PAIR;
            end
            // Bit rotates touch only the low byte and carry; digit rotates touch the low nibble and memory
            OP_ROT_RIGHT: begin
                calc.acc_pair[7:0] = {a[0], a[7:1]};
                calc.flags.cy = a[0];
                cyc = CYC_ROT;
            end
            OP_ROT_LEFT: begin
                calc.acc_pair[7:0] = {a[6:0], a[7]};
                calc.flags.cy = a[7];
                cyc = CYC_ROT;
            end
            OP_ROT_RIGHT_CARRY: begin
                calc.acc_pair[7:0] = {cmd.flags.cy, a[7:1]};
                calc.flags.cy = a[0];
                cyc = CYC_ROT;
            end
            OP_ROT_LEFT_CARRY: begin
                calc.acc_pair[7:0] = {a[6:0], cmd.flags.cy};
                calc.flags.cy = a[7];
                cyc = CYC_ROT;
            end
            OP_DIGIT_ROT_RIGHT: begin
                calc.acc_pair[3:0] = cmd.mem[3:0];
                calc.mem = {a[3:0], cmd.mem[7:4]};
                if (cmd.in_hsram) begin
                    cyc = CYC_DIGIT;
                end else begin
                    cyc = CYC_DIGIT_SLOW;
                end
            end
            OP_DIGIT_ROT_LEFT: begin
                calc.acc_pair[3:0] = cmd.mem[7:4];
                calc.mem = {cmd.mem[3:0], a[3:0]};
                if (cmd.in_hsram) begin
                    cyc = CYC_DIGIT;
                end else begin
                    cyc = CYC_DIGIT_SLOW;
                end
            end
            OP_DEC_ADJUST_ADD: begin
                bres = a + adj;
                calc.acc_pair[7:0] = bres;
                calc.flags.z  = (bres == 8'h00);
                calc.flags.ac = adj_ac;
                calc.flags.cy = adj_cy;
                cyc = CYC_ADJUST;
            end
            OP_DEC_ADJUST_SUB: begin
                bres = a - adj;
                calc.acc_pair[7:0] = bres;
                calc.flags.z  = (bres == 8'h00);
                calc.flags.ac = adj_ac;
                calc.flags.cy = adj_cy;
                cyc = CYC_ADJUST;
            end
            // Bit moves pick the memory byte or the register
            OP_BIT_TO_CARRY: begin
                calc.flags.cy = src[cmd.bit_pos];
                if (!cmd.use_mem) begin
                    cyc = CYC_BIT_REG;
                end else if (cmd.in_hsram) begin
                    cyc = CYC_BIT_MEM;
                end else begin
                    cyc = CYC_BIT_RD_SLOW;
                end
            end
            OP_CARRY_TO_BIT: begin
                bres = src;
                bres[cmd.bit_pos] = cmd.flags.cy;
                if (cmd.use_mem) begin
                    calc.mem = bres;
                end else begin
                    calc.operand[7:0] = bres;
                end
                if (!cmd.use_mem) begin
                    cyc = CYC_BIT_REG;
                end else if (cmd.in_hsram) begin
                    cyc = CYC_BIT_MEM;
                end else begin
                    cyc = CYC_BIT_WR_SLOW;
                end
            end
            default: begin
                cyc = CYC_ROT;
            end
        endcase
    end

    // Sequencer: result is held back until the cost has elapsed
    always_comb begin
        state_nxt = state_r;
        left_nxt  = left_r;
        hold_nxt  = hold_r;
        res_nxt   = res;
        busy_nxt  = busy;
        done_nxt  = 1'b0;
        case (state_r)
            ST_IDLE: begin
                // Operands are sampled on this edge only
                if (start) begin
                    hold_nxt  = calc;
                    left_nxt  = cyc;
                    busy_nxt  = 1'b1;
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                // A start while running is dropped, with no sign
                // Only cpu_clock periods count, not mclk edges
                if (tick) begin
                    if (left_r == 5'h01) begin
                        res_nxt   = hold_r;
                        done_nxt  = 1'b1;
                        busy_nxt  = 1'b0;
                        left_nxt  = 5'h00;
                        state_nxt = ST_IDLE;
                    end else begin
                        left_nxt = left_r - 5'h01;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                busy_nxt  = 1'b0;
                left_nxt  = 5'h00;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            left_r  <= 5'h00;
            hold_r  <= '0;
            res     <= '0;
            busy    <= 1'b0;
            done    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            left_r  <= left_nxt;
            hold_r  <= hold_nxt;
            res     <= res_nxt;
            busy    <= busy_nxt;
            done    <= done_nxt;
        end
    end
endmodule

// >>> dv/arith_datapath_props.sv
// Checker: handshake timing and selected results of arith_datapath.
// Assumes one clock mclk and synchronous active-high rst.
`timescale 1ns/100ps
module arith_datapath_props (
    input wire logic               mclk,
    input wire logic               rst,
    input wire logic [2:0]         clock_sel,
    input wire logic               start,
    input wire arith_pkg::cmd_type cmd,
    input wire logic               busy,
    input wire logic               done,
    input wire arith_pkg::res_type res
);
    import arith_pkg::*;
    cmd_type    cap_r;
    cmd_type    cap_nxt;
    logic [7:0] a;

    // Command kept from its take edge; refused starts never land here
    always_comb begin
        cap_nxt = cap_r;
        if (start && !busy) begin
            cap_nxt = cmd;
        end
    end
    always_ff @(posedge mclk) begin
        cap_r <= cap_nxt;
    end
    assign a = cap_r.acc_pair[7:0];

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // Shortest operation costs two cycles at the fastest clock
    property p_take;
        start && !busy && clock_sel == 3'h0 |=> busy [*2];
    endproperty
    a_take: assert property (p_take)
        else $error("busy not held after start");
    property p_done;
        done |-> !busy ##1 !done;
    endproperty
    a_done: assert property (p_done)
        else $error("done not a single idle pulse");
    property p_fell;
        $fell(busy) |-> done;
    endproperty
    a_fell: assert property (p_fell)
        else $error("busy ended without done");

    // Results tied to the captured operands
    property p_add;
        done && cap_r.op == OP_WORD_ADD_IMM |->
            res.acc_pair == 16'(cap_r.acc_pair + cap_r.imm)
            && res.flags.cy == (res.acc_pair < cap_r.acc_pair);
    endproperty
    a_add: assert property (p_add)
        else $error("word add wrong");
    property p_mul;
        done && cap_r.op == OP_UNSIGNED_MUL |-> res.flags == cap_r.flags
            && res.acc_pair == a * cap_r.x_reg;
    endproperty
    a_mul: assert property (p_mul)
        else $error("multiply wrong");
    property p_div;
        done && cap_r.op == OP_UNSIGNED_DIV && cap_r.c_reg != 8'h00 |->
            res.acc_pair == cap_r.acc_pair / cap_r.c_reg
            && res.c_reg == 8'(cap_r.acc_pair % cap_r.c_reg);
    endproperty
    a_div: assert property (p_div)
        else $error("divide wrong");
    property p_inc;
        done && cap_r.op inside {OP_BYTE_INC, OP_BYTE_DEC} |->
            res.flags.cy == cap_r.flags.cy;
    endproperty
    a_inc: assert property (p_inc)
        else $error("byte step touched carry");
    property p_pair;
        done && cap_r.op inside {OP_PAIR_INC, OP_PAIR_DEC} |->
            res.flags == cap_r.flags && res.operand == (cap_r.op ==
            OP_PAIR_INC ? cap_r.operand + 16'h1 : cap_r.operand - 16'h1);
    endproperty
    a_pair: assert property (p_pair)
        else $error("pair step wrong");
    property p_rc;
        done && cap_r.op == OP_ROT_RIGHT_CARRY |-> res.flags.cy == a[0]
            && res.acc_pair[7:0] == {cap_r.flags.cy, a[7:1]};
    endproperty
    a_rc: assert property (p_rc)
        else $error("rotate through carry wrong");

    c_b2b: cover property (done && start);
    c_refuse: cover property (start && busy);
    c_div0: cover property (done && cap_r.op == OP_UNSIGNED_DIV
        && cap_r.c_reg == 8'h00);
endmodule

bind arith_datapath arith_datapath_props chk (
    .mclk(mclk), .rst(rst), .clock_sel(clock_sel), .start(start),
    .cmd(cmd), .busy(busy), .done(done), .res(res)
);

// >>> dv/arith_datapath_tb_top.sv
// Self-checking bench for arith_datapath: random and edge operands.
// Assumes the design and its checker are compiled before this file.
`timescale 1ns/100ps
module arith_datapath_tb_top;
    import arith_pkg::*;
    typedef struct {
        res_type r;
        int      lo;
        int      hi;
    } check_type;

    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic [2:0] clock_sel = 3'h0;
    logic       start = 1'b0;
    cmd_type    cmd = '0;
    logic       busy;
    logic       done;
    res_type    res;
    check_type  q[$];
    check_type  m;
    res_type    g;
    int         errors = 0;
    int         checked = 0;
    int         bcnt = 0;
    int         cyc = 0;

    arith_datapath uut (
        .mclk(mclk), .rst(rst), .clock_sel(clock_sel), .start(start),
        .cmd(cmd), .busy(busy), .done(done), .res(res)
    );

    // 20 MHz
    always #25 mclk = ~mclk;

    // Reference result and cycle cost of one command
    function automatic res_type model(cmd_type c, output int n);
        res_type     r;
        logic [7:0]  a;
        logic [7:0]  v;
        logic [7:0]  w;
        logic [16:0] s;
        logic [4:0]  h;
        logic        sub;
        logic        left;
        logic        b;
        r = {c.acc_pair, c.c_reg, c.operand, c.mem, c.flags};
        a = c.acc_pair[7:0];
        v = c.use_mem ? c.mem : c.operand[7:0];
        sub = c.op inside {OP_WORD_SUB_IMM, OP_WORD_COMPARE_IMM, OP_BYTE_DEC,
            OP_PAIR_DEC, OP_DEC_ADJUST_SUB};
        left = c.op inside {OP_ROT_LEFT, OP_ROT_LEFT_CARRY, OP_DIGIT_ROT_LEFT};
        n = 2;
        case (c.op)
            OP_WORD_ADD_IMM, OP_WORD_SUB_IMM, OP_WORD_COMPARE_IMM: begin
                s = sub ? {1'b0, c.acc_pair} - c.imm
                    : {1'b0, c.acc_pair} + c.imm;
                h = sub ? {1'b0, a[3:0]} - c.imm[3:0]
                    : {1'b0, a[3:0]} + c.imm[3:0];
                r.flags = {s[15:0] == 16'h0000, h[4], s[16]};
                r.acc_pair = c.op == OP_WORD_COMPARE_IMM ? c.acc_pair : s[15:0];
                n = 6;
            end
            OP_UNSIGNED_MUL: begin
                r.acc_pair = a * c.x_reg;
                n = 16;
            end
            OP_UNSIGNED_DIV: begin
                r.acc_pair = c.c_reg == 8'h00 ? 16'hffff
                    : c.acc_pair / c.c_reg;
                r.c_reg = c.c_reg == 8'h00 ? c.c_reg
                    : 8'(c.acc_pair % c.c_reg);
                n = 25;
            end
            OP_BYTE_INC, OP_BYTE_DEC: begin
                w = sub ? v - 8'h01 : v + 8'h01;
                r.flags.z = w == 8'h00;
                r.flags.ac = v[3:0] == (sub ? 4'h0 : 4'hf);
                r.mem = c.use_mem ? w : c.mem;
                r.operand[7:0] = c.use_mem ? c.operand[7:0] : w;
                n = c.use_mem ? (c.in_hsram ? 4 : 6) : 2;
            end
            OP_PAIR_INC, OP_PAIR_DEC: begin
                r.operand = sub ? c.operand - 16'h1 : c.operand + 16'h1;
                n = 4;
            end
            OP_ROT_RIGHT, OP_ROT_LEFT, OP_ROT_RIGHT_CARRY,
            OP_ROT_LEFT_CARRY: begin
                b = c.op inside {OP_ROT_RIGHT, OP_ROT_LEFT}
                    ? (left ? a[7] : a[0]) : c.flags.cy;
                r.acc_pair[7:0] = left ? {a[6:0], b} : {b, a[7:1]};
                r.flags.cy = left ? a[7] : a[0];
            end
            OP_DIGIT_ROT_RIGHT, OP_DIGIT_ROT_LEFT: begin
                r.acc_pair[3:0] = left ? c.mem[7:4] : c.mem[3:0];
                r.mem = left ? {c.mem[3:0], a[3:0]} : {a[3:0], c.mem[7:4]};
                n = c.in_hsram ? 10 : 12;
            end
            OP_DEC_ADJUST_ADD, OP_DEC_ADJUST_SUB: begin
                w = a;
                r.flags.ac = 1'b0;
                if (a[3:0] > 4'h9 || c.flags.ac) begin
                    w = sub ? w - 8'h06 : w + 8'h06;
                    // Carry or borrow out of bit 3 of the low fix
                    r.flags.ac = sub ? a[3:0] < 4'h6 : a[3:0] > 4'h9;
                end
                if (a > 8'h99 || c.flags.cy) begin
                    w = sub ? w - 8'h60 : w + 8'h60;
                    r.flags.cy = 1'b1;
                end
                r.acc_pair[7:0] = w;
                r.flags.z = w == 8'h00;
                n = 4;
            end
            OP_BIT_TO_CARRY: begin
                r.flags.cy = v[c.bit_pos];
                n = !c.use_mem ? 4 : c.in_hsram ? 6 : 7;
            end
            default: begin
                v[c.bit_pos] = c.flags.cy;
                r.mem = c.use_mem ? v : c.mem;
                r.operand[7:0] = c.use_mem ? c.operand[7:0] : v;
                n = !c.use_mem ? 4 : c.in_hsram ? 6 : 8;
            end
        endcase
        return r;
    endfunction

    // Random operands; pass 0 divides by zero, pass 1 uses all ones with an immediate of 1 for ops before the decimal adjusts
    function automatic cmd_type rnd(op_type o, int i);
        logic [95:0] b;
        cmd_type     c;
        b = {$urandom, $urandom, $urandom};
        c = b[$bits(cmd_type)-1:0];
        c.op = o;
        if (o inside {OP_DEC_ADJUST_ADD, OP_DEC_ADJUST_SUB}) begin
            c.acc_pair[7:4] = 4'($urandom_range(8, 1));
        end
        if (i == 0) begin
            c.c_reg = 8'h00;
        end
        if (i == 1 && c.op < OP_DEC_ADJUST_ADD) begin
            c.acc_pair = 16'hffff;
            c.imm = 16'h0001;
            c.operand = 16'hffff;
            c.mem = 8'hff;
        end
        return c;
    endfunction

    task automatic chk(string nm, logic [63:0] e, logic [63:0] v);
        checked++;
        if (e !== v) begin
            errors++;
            $display("[ERR] %s exp %h got %h", nm, e, v);
        end
    endtask

    // Called just after a rising edge; returns at the take edge
    task automatic issue(cmd_type c, logic [2:0] s);
        check_type e;
        int        n;
        int        sh;
        e.r = model(c, n);
        sh = s > 3'h4 ? 4 : int'(s);
        e.lo = ((n - 1) << sh) + 1;
        e.hi = n << sh;
        q.push_back(e);
        clock_sel <= s;
        cmd <= c;
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
    endtask

    task automatic idle();
        int t;
        t = 0;
        do begin
            @(negedge mclk);
            t++;
        end while (done !== 1'b1 && t < 600);
        if (done !== 1'b1) begin
            errors++;
            $display("[ERR] done exp 1 got 0");
        end
        @(posedge mclk);
    endtask

    task automatic complete_run();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Oldest expectation is judged whenever a result appears
    always @(negedge mclk) begin
        if (busy === 1'b1) begin
            bcnt++;
        end
        if (done === 1'b1) begin
            if (q.size() == 0) begin
                errors++;
                $display("[ERR] done exp 0 got 1");
            end else begin
                m = q.pop_front();
                g = res;
                chk("res", 64'(m.r), 64'(g));
                chk("cycles", 64'(m.hi), 64'(bcnt >= m.lo && bcnt <= m.hi
                    ? m.hi : bcnt));
            end
            bcnt = 0;
        end
    end

    // Cycle ceiling; a hang counts as a mismatch
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            complete_run();
        end
    end

    initial begin
        void'($urandom(2));
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk("idle", 64'({busy, done, res}), 64'h0);
        @(posedge mclk);
        // Every operation; later passes slow the cpu clock at random
        for (int i = 0; i < 24; i++) begin
            for (int k = 0; k <= int'(OP_CARRY_TO_BIT); k++) begin
                issue(rnd(op_type'(5'(k)), i),
                    i < 20 ? 3'h0 : 3'($urandom));
                idle();
            end
        end
        // Refused start while busy, then a start in the done cycle
        issue(rnd(OP_UNSIGNED_MUL, 5), 3'h0);
        @(posedge mclk);
        cmd <= rnd(OP_ROT_LEFT, 5);
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        repeat (14) @(posedge mclk);
        issue(rnd(OP_ROT_LEFT, 6), 3'h0);
        idle();
        chk("pending", 64'(q.size()), 64'h0);
        complete_run();
    end
endmodule
